// ---- logic/dbs_params.svh ----
// Constants for the burst SRAM pin interface block
`ifndef DBS_PARAMS_SVH
`define DBS_PARAMS_SVH
`define DBS_DATA_W 18
`define DBS_ADDR_W 6
`define DBS_BYTE_W 9
`define DBS_FIFO_DEPTH 8
`define DBS_RD_LAT 2
`define DBS_TERM_LOW 1'b0
`define DBS_TERM_HIGH 1'b1
`endif

// ---- logic/dbs_pkg.sv ----
// Types shared by the burst SRAM pin interface modules
package dbs_pkg;
   typedef enum logic [1:0] {
      DBS_IDLE,
      DBS_WR2,
      DBS_RD2
   } dbs_state_t;
   typedef struct packed {
      logic [17:0] data;
      logic last;
   } dbs_beat_t;
endpackage

// ---- logic/dbs_stream_if.sv ----
// Valid and ready stream carrier between the block's own modules
interface dbs_stream_if #(parameter int W = 19) ();
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ---- logic/dbs_fifo.sv ----
// Small FIFO with valid and ready on both sides
module dbs_fifo #(
   parameter int W = 19,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   dbs_stream_if.snk in_s,
   dbs_stream_if.src out_s
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin
         $error("dbs_fifo: DEPTH must be a power of two, at least 2");
      end
   end
   logic [W-1:0] mem [DEPTH];
   logic [AW:0] wp_q;
   logic [AW:0] rp_q;
   wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
   wire empty = (wp_q == rp_q);
   wire push = in_s.valid && !full;
   wire pop = out_s.ready && !empty;
   assign in_s.ready = !full;
   assign out_s.valid = !empty;
   assign out_s.data = mem[rp_q[AW-1:0]];
   // Pointers carry one extra wrap bit so full and empty differ
   always_ff @(posedge clk) begin
      if (rst) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         if (push) wp_q <= wp_q + 1'b1;
         if (pop) rp_q <= rp_q + 1'b1;
      end
   end
   // Storage is not reset; only pointers define content
   always_ff @(posedge clk) begin
      if (push) mem[wp_q[AW-1:0]] <= in_s.data;
   end
endmodule // dbs_fifo

// ---- logic/dbs_echo.sv ----
// Edge finder for the link clocks and echo clock generator
module dbs_echo (
   input wire logic clk,
   input wire logic rst,
   input wire logic k_pin,
   input wire logic kn_pin,
   output logic k_rise,
   output logic kn_rise,
   output logic echo_q,
   output logic echo_n_q
);
   logic k_s1_q;
   logic k_s2_q;
   logic k_s3_q;
   logic kn_s1_q;
   logic kn_s2_q;
   logic kn_s3_q;
   // Two flops before any logic; third flop keeps edge finding off stage one
   always_ff @(posedge clk) begin
      if (rst) begin
         {k_s1_q, k_s2_q, k_s3_q} <= 3'h0;
         {kn_s1_q, kn_s2_q, kn_s3_q} <= 3'h0;
      end else begin
         {k_s1_q, k_s2_q, k_s3_q} <= {k_pin, k_s1_q, k_s2_q};
         {kn_s1_q, kn_s2_q, kn_s3_q} <= {kn_pin, kn_s1_q, kn_s2_q};
      end
   end
   assign k_rise = k_s2_q && !k_s3_q;
   assign kn_rise = kn_s2_q && !kn_s3_q;
   // Echo clocks follow the positive input clock, so they run free
   always_ff @(posedge clk) begin
      if (rst) begin
         echo_q <= 1'b0;
         echo_n_q <= 1'b1;
      end else begin
         echo_q <= k_s2_q;
         echo_n_q <= !k_s2_q;
      end
   end
endmodule // dbs_echo

// ---- logic/dbs_sram_if.sv ----
// Double data rate burst SRAM pin interface with internal core
// Contract
// - Address sampled on rising positive input clock for every access.
// - One shared address port serves both reads and writes.
// - Storage is two equal arrays, each half the words at full width.
// - With load low, direction high means read, low means write.
// - Read valid indicator marks read data and moves with echo edges.
// - Termination range latched once at power-up from select pin.
// - Accesses start on rising positive clock, which captures and launches.
// - Rising negative clock handles the second write and read beat.
// - Load low defines a cycle; every transfer moves exactly two words.
// - Data outputs released whenever no read is selected.
// - Byte selects sampled with their byte; deselected bytes stay unchanged.
// - Free-running echo clocks follow the positive input clock.
`include "dbs_params.svh"
module dbs_sram_if #(
   parameter int DATA_W = `DBS_DATA_W,
   parameter int ADDR_W = `DBS_ADDR_W,
   parameter int FIFO_DEPTH = `DBS_FIFO_DEPTH
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic K,
   input wire logic K_N,
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic CYCLE_LOAD_N,
   input wire logic RW,
   input wire logic [1:0] BYTE_WRITE_SELECT_N,
   input wire logic [DATA_W-1:0] DQ_IN,
   output logic [DATA_W-1:0] DQ_OUT,
   output logic DQ_OE,
   output logic READ_DATA_VALID,
   output logic ECHO_CLOCK,
   output logic ECHO_CLOCK_N,
   input wire logic TERMINATION_RANGE_SELECT,
   output logic TERMINATION_RANGE
);
   localparam int BW = `DBS_BYTE_W;
   localparam int NB = DATA_W / BW;
   initial begin
      if (DATA_W != 18 || NB != 2 || ADDR_W < 1) begin
         $error("dbs_sram_if: only the 18-bit, two-lane variant is served");
      end
   end

   // Pin inputs pass two flops before use
   logic [ADDR_W-1:0] a_s1_q, a_s2_q;
   logic ld_s1_q, ld_s2_q, rw_s1_q, rw_s2_q, ts_s1_q, ts_s2_q;
   logic [NB-1:0] bs_s1_q, bs_s2_q;
   logic [DATA_W-1:0] d_s1_q, d_s2_q;
   always_ff @(posedge CLK) begin
      if (RST) begin
         a_s1_q <= '0;
         a_s2_q <= '0;
         {ld_s1_q, ld_s2_q, rw_s1_q, rw_s2_q} <= 4'hF;
         {ts_s1_q, ts_s2_q} <= 2'h3;
         bs_s1_q <= '1;
         bs_s2_q <= '1;
         d_s1_q <= '0;
         d_s2_q <= '0;
      end else begin
         a_s1_q <= ADDR;
         a_s2_q <= a_s1_q;
         {ld_s1_q, ld_s2_q} <= {CYCLE_LOAD_N, ld_s1_q};
         {rw_s1_q, rw_s2_q} <= {RW, rw_s1_q};
         {ts_s1_q, ts_s2_q} <= {TERMINATION_RANGE_SELECT, ts_s1_q};
         bs_s1_q <= BYTE_WRITE_SELECT_N;
         bs_s2_q <= bs_s1_q;
         d_s1_q <= DQ_IN;
         d_s2_q <= d_s1_q;
      end
   end

   // Link clock edges and echo clocks
   logic k_rise, kn_rise;
   dbs_echo u_echo (
      .clk(CLK),
      .rst(RST),
      .k_pin(K),
      .kn_pin(K_N),
      .k_rise(k_rise),
      .kn_rise(kn_rise),
      .echo_q(ECHO_CLOCK),
      .echo_n_q(ECHO_CLOCK_N)
   );

   // Termination range caught once, after the pin pipe has refilled;
   // reading at the first edge would latch the reset value instead
   logic [1:0] term_wait_q;
   logic term_q;
   always_ff @(posedge CLK) begin
      if (RST) begin
         term_wait_q <= 2'h0;
         term_q <= `DBS_TERM_HIGH;
      end else if (term_wait_q != 2'h3) begin
         term_wait_q <= term_wait_q + 2'h1;
         if (term_wait_q == 2'h2) begin
            term_q <= ts_s2_q ? `DBS_TERM_HIGH : `DBS_TERM_LOW;
         end
      end
   end
   assign TERMINATION_RANGE = term_q;

   // Two equal arrays: beat 0 goes to array 0, beat 1 to array 1
   localparam int WORDS = 1 << ADDR_W;
   logic [DATA_W-1:0] arr0 [WORDS];
   logic [DATA_W-1:0] arr1 [WORDS];

   // Cycle decode on a rising positive clock edge
   wire load = k_rise && !ld_s2_q;
   wire is_read = rw_s2_q;
   dbs_pkg::dbs_state_t st_q, st_d;
   logic [ADDR_W-1:0] addr_q;
   logic [NB-1:0] be1_q;

   // Second beat waits for the negative clock edge
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         dbs_pkg::DBS_IDLE: begin
            if (load) st_d = is_read ? dbs_pkg::DBS_RD2 : dbs_pkg::DBS_WR2;
         end
         dbs_pkg::DBS_WR2: begin
            if (kn_rise) st_d = dbs_pkg::DBS_IDLE;
         end
         dbs_pkg::DBS_RD2: begin
            if (kn_rise) st_d = dbs_pkg::DBS_IDLE;
         end
      endcase
   end
   always_ff @(posedge CLK) begin
      if (RST) st_q <= dbs_pkg::DBS_IDLE;
      else st_q <= st_d;
   end
   // One shared address latched for either direction
   always_ff @(posedge CLK) begin
      if (RST) addr_q <= '0;
      else if (load) addr_q <= a_s2_q;
   end
   assign be1_q = bs_s2_q;

   // Byte-lane writes; a deselected lane keeps its old contents
   wire wr0 = load && !is_read;
   wire wr1 = (st_q == dbs_pkg::DBS_WR2) && kn_rise;
   genvar gb;
   generate
      for (gb = 0; gb < NB; gb++) begin : g_lane
         always_ff @(posedge CLK) begin
            if (wr0 && !bs_s2_q[gb])
               arr0[a_s2_q][gb*BW +: BW] <= d_s2_q[gb*BW +: BW];
            if (wr1 && !be1_q[gb])
               arr1[addr_q][gb*BW +: BW] <= d_s2_q[gb*BW +: BW];
         end
      end
   endgenerate

   // Read beats queue through the FIFO so launch can follow clock edges
   dbs_stream_if #(.W(DATA_W + 1)) rq_in ();
   dbs_stream_if #(.W(DATA_W + 1)) rq_out ();
   dbs_fifo #(.W(DATA_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(CLK),
      .rst(RST),
      .in_s(rq_in.snk),
      .out_s(rq_out.src)
   );
   wire rd0 = load && is_read;
   wire rd1 = (st_q == dbs_pkg::DBS_RD2) && kn_rise;
   assign rq_in.valid = rd0 || rd1;
   assign rq_in.data = rd0 ? {1'b0, arr0[a_s2_q]} : {1'b1, arr1[addr_q]};

   // Launch: first beat on positive edge, second on negative edge
   wire launch_ok = rq_out.data[DATA_W] ? kn_rise : k_rise;
   assign rq_out.ready = launch_ok;
   wire launch = rq_out.valid && launch_ok;
   wire any_edge = k_rise || kn_rise;
   logic [DATA_W-1:0] q_q;
   logic oe_q;
   // Output flops move only on link edges, which keeps valid on echo edges
   always_ff @(posedge CLK) begin
      if (RST) begin
         q_q <= '0;
         oe_q <= 1'b0;
      end else if (any_edge) begin
         oe_q <= launch;
         if (launch) q_q <= rq_out.data[DATA_W-1:0];
      end
   end
   assign DQ_OUT = q_q;
   assign DQ_OE = oe_q;
   assign READ_DATA_VALID = oe_q;
endmodule // dbs_sram_if

// ---- verification/dbs_sram_if_asserts.sv ----
// Checker for the burst SRAM pin interface ports
module dbs_sram_if_asserts #(parameter int DATA_W = 18) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CYCLE_LOAD_N,
   input wire logic RW,
   input wire logic [DATA_W-1:0] DQ_OUT,
   input wire logic DQ_OE,
   input wire logic READ_DATA_VALID,
   input wire logic ECHO_CLOCK,
   input wire logic ECHO_CLOCK_N,
   input wire logic TERMINATION_RANGE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   logic [5:0] rd_age_q;
   // Cycles since a read load; saturates so an old read never looks new
   always_ff @(posedge CLK) begin
      if (RST || (!CYCLE_LOAD_N && RW)) rd_age_q <= 6'h00;
      else if (rd_age_q != 6'h3F) rd_age_q <= rd_age_q + 6'h01;
   end
   property p_valid_oe; READ_DATA_VALID == DQ_OE; endproperty
   a_valid_oe: assert property (p_valid_oe)
      else $error("valid flag differs from enable");
   property p_echo_pair; ECHO_CLOCK_N != ECHO_CLOCK; endproperty
   a_echo_pair: assert property (p_echo_pair)
      else $error("echo pair not complementary");
   property p_echo_runs; $stable(ECHO_CLOCK) |-> ##[1:6] $changed(ECHO_CLOCK);
   endproperty
   a_echo_runs: assert property (p_echo_runs)
      else $error("echo clock stopped");
   property p_range_hold;
      !$past(RST) && !$past(RST, 2) && !$past(RST, 3) && !$past(RST, 4)
         |-> $stable(TERMINATION_RANGE);
   endproperty
   a_range_hold: assert property (p_range_hold)
      else $error("range changed after power-up");
   property p_oe_echo; $rose(DQ_OE) |-> ##[0:2] ECHO_CLOCK; endproperty
   a_oe_echo: assert property (p_oe_echo)
      else $error("read data not in echo high phase");
   property p_oe_len; $rose(DQ_OE) |-> DQ_OE [*7]; endproperty
   a_oe_len: assert property (p_oe_len)
      else $error("read burst shorter than two beats");
   property p_oe_cause; $rose(DQ_OE) |-> rd_age_q < 6'h28; endproperty
   a_oe_cause: assert property (p_oe_cause)
      else $error("data driven with no read");
   property p_dq_stand;
      DQ_OE && $changed(DQ_OUT) |=> (!DQ_OE || $stable(DQ_OUT)) [*3];
   endproperty
   a_dq_stand: assert property (p_dq_stand)
      else $error("read beat too short");
endmodule // dbs_sram_if_asserts
bind dbs_sram_if dbs_sram_if_asserts #(.DATA_W(DATA_W)) i_dbs_sram_if_asserts (
   .CLK(CLK), .RST(RST), .CYCLE_LOAD_N(CYCLE_LOAD_N), .RW(RW),
   .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .READ_DATA_VALID(READ_DATA_VALID),
   .ECHO_CLOCK(ECHO_CLOCK), .ECHO_CLOCK_N(ECHO_CLOCK_N),
   .TERMINATION_RANGE(TERMINATION_RANGE));

// ---- verification/dbs_ctrl_model.sv ----
// Memory controller model: link clocks and two-word bursts
module dbs_ctrl_model (
   input wire logic clk,
   output logic k,
   output logic k_n,
   output logic [5:0] addr,
   output logic load_n,
   output logic rw,
   output logic [1:0] sel_n,
   output logic [17:0] dq
);
   timeunit 1ns;
   timeprecision 1ns;
   assign k_n = ~k;
   // Free-running input clock, offset so its edges miss clk edges
   initial begin
      k = 1'b0;
      load_n = 1'b1;
      rw = 1'b1;
      addr = 6'h00;
      sel_n = 2'h3;
      dq = 18'h0_0000;
      #7;
      forever #80 k = ~k;
   end
   // Load and beat zero held across a K rise; beat one across the next
   // K_N rise, so each beat stands at the edge that captures it
   task automatic xfer(input logic r, input logic [5:0] a,
      input logic [17:0] d0, d1, input logic [1:0] s0, s1);
      @(posedge k_n);
      @(negedge clk);
      load_n = 1'b0;
      rw = r;
      addr = a;
      sel_n = s0;
      dq = r ? ~dq : d0;
      @(posedge k);
      @(negedge clk);
      load_n = 1'b1;
      addr = ~a;
      sel_n = s1;
      dq = r ? ~dq : d1;
      @(posedge k_n);
      @(negedge clk);
      dq = ~dq; // Released data never shows the last value
   endtask
endmodule // dbs_ctrl_model

// ---- verification/tb_dbs_sram_if.sv ----
// Self-checking bench for the burst SRAM pin interface
module tb_dbs_sram_if;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic trs = 1'b0;
   logic k, k_n, load_n, rw, oe, vld, ec, ec_n, tr;
   logic [5:0] addr;
   logic [1:0] sel_n;
   logic [17:0] ctl_dq, dq_out, dq_pin;
   int mismatches = 0;
   int compares = 0;
   always #10 clk = ~clk;
   // Shared data pin: the device wins while it drives
   assign dq_pin = oe ? dq_out : ctl_dq;
   dbs_sram_if i_dbs_sram_if (.CLK(clk), .RST(rst), .K(k), .K_N(k_n),
      .ADDR(addr), .CYCLE_LOAD_N(load_n), .RW(rw),
      .BYTE_WRITE_SELECT_N(sel_n), .DQ_IN(dq_pin), .DQ_OUT(dq_out),
      .DQ_OE(oe), .READ_DATA_VALID(vld), .ECHO_CLOCK(ec),
      .ECHO_CLOCK_N(ec_n), .TERMINATION_RANGE_SELECT(trs),
      .TERMINATION_RANGE(tr));
   dbs_ctrl_model i_dbs_ctrl_model (.clk(clk), .k(k), .k_n(k_n),
      .addr(addr), .load_n(load_n), .rw(rw), .sel_n(sel_n), .dq(ctl_dq));
   task automatic chk_w(input string n, input logic [17:0] e, g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_b(input string n, input logic e, g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic close_out;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [5:0] a, input logic [17:0] d0, d1,
      input logic [1:0] s0, s1);
      i_dbs_ctrl_model.xfer(1'b0, a, d0, d1, s0, s1);
   endtask
   // Read burst; beat timing counted from the enable rising
   task automatic rd(input logic [5:0] a, input logic [17:0] e0, e1);
      int n;
      i_dbs_ctrl_model.xfer(1'b1, a, 18'h0_0000, 18'h0_0000, 2'h3, 2'h3);
      for (n = 0; n < 40 && oe !== 1'b1; n++) @(negedge clk);
      chk_b("enable", 1'b1, oe);
      chk_b("valid", 1'b1, vld);
      @(negedge clk);
      chk_w("beat0", e0, dq_out);
      repeat (4) @(negedge clk);
      chk_w("beat1", e1, dq_out);
      repeat (4) @(negedge clk);
      chk_b("enable idle", 1'b0, oe);
   endtask
   // Range chosen at reset must ignore later pin changes
   task automatic t_range;
      chk_b("range", 1'b0, tr);
      chk_b("enable reset", 1'b0, oe);
      trs = 1'b1;
      repeat (10) @(negedge clk);
      chk_b("range held", 1'b0, tr);
   endtask
   // Full bursts at both ends of the address space, read back
   task automatic t_burst;
      wr(6'h3F, 18'h1_2345, 18'h2_ABCD, 2'h0, 2'h0);
      wr(6'h00, 18'h3_FFFF, 18'h0_0000, 2'h0, 2'h0);
      rd(6'h3F, 18'h1_2345, 18'h2_ABCD);
      rd(6'h00, 18'h3_FFFF, 18'h0_0000);
   endtask
   // Each beat writes only its selected lane; the other keeps old data
   task automatic t_lanes;
      wr(6'h3F, 18'h0_0000, 18'h0_0000, 2'h2, 2'h1);
      rd(6'h3F, 18'h1_2200, 18'h0_01CD);
   endtask
   initial begin
      repeat (10) @(negedge clk);
      rst = 1'b0;
      repeat (8) @(negedge clk);
      t_range;
      t_burst;
      t_lanes;
      close_out;
   end
   // Watchdog far beyond the few microseconds of traffic
   initial begin
      #100000;
      mismatches++;
      close_out;
   end
endmodule // tb_dbs_sram_if
